// ### grlc_pkg.sv
// constants, coefficient table and state types of the gyro rate loop compensator
package grlc_pkg;

    // ==========================================================
    // clock and sample timing
    localparam int CLK_HZ           = 40_000_000;
    localparam int CLK_PERIOD_NS    = 25;
    localparam int SAMPLE_RATE_HZ   = 4020;
    localparam int SAMPLE_PERIOD_US = 249;
    localparam int TICK_CYCLES      = CLK_HZ / SAMPLE_RATE_HZ;
    localparam int TICK_W           = 16;
    localparam int FRAME_RATE_HZ    = 30;
    localparam int TICKS_PER_FRAME  = SAMPLE_RATE_HZ / FRAME_RATE_HZ;
    localparam int FRAME_W          = 8;
    localparam int SH_SETTLE_NS     = 1000;
    localparam int SH_CYCLES        = (SH_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int START_PULSE_NS   = 100;
    localparam int START_CYCLES     = (START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIME_W           = 8;

    // ==========================================================
    // data widths
    localparam int ADC_W      = 12;
    localparam int DAC_W      = 12;
    localparam int SAMPLE_W   = 24;
    localparam int COEF_W     = 32;
    localparam int COEF_FRAC  = 16;
    localparam int ACC_W      = 60;
    localparam int CH_W       = 1;
    localparam int WORD_W     = CH_W + ADC_W;
    localparam int FIFO_DEPTH = 32;
    localparam logic [CH_W-1:0] CH_RATE = 1'h0;
    localparam logic [CH_W-1:0] CH_POS  = 1'h1;
    localparam logic [ACC_W-1:0] ROUND_HALF =
        {{(ACC_W - COEF_FRAC){1'b0}}, 1'b1, {(COEF_FRAC - 1){1'b0}}};

    // ==========================================================
    // stage map: taps are b0*x, b1*x1, b2*x2, a1*y1, a2*y2 (a taps subtract)
    localparam int STAGE_W    = 4;
    localparam int TAP_W      = 3;
    localparam int TAPS       = 5;
    localparam int NUM_STAGES = 10;
    localparam int FIRST_A_TAP = 3;
    localparam logic [STAGE_W-1:0] RATE_FIRST = 4'h0;
    localparam logic [STAGE_W-1:0] RATE_LAST  = 4'h7;
    localparam logic [STAGE_W-1:0] POS_FIRST  = 4'h8;
    localparam logic [STAGE_W-1:0] POS_LAST   = 4'h9;

    // coefficients scaled by 2^16, gains folded into the numerators
    localparam logic signed [COEF_W-1:0] COEF_TABLE [NUM_STAGES*TAPS] = '{
        32'sd8153, 32'sd8153, 32'sd0, -32'sd65520, 32'sd0,                  // rate 1st order
        32'sd49460681, -32'sd98142847, 32'sd48694041, -32'sd82248, 32'sd35874, // rate 2nd
        32'sd63489, 32'sd120200, 32'sd63489, 32'sd120200, 32'sd61443,       // 1800 Hz
        32'sd54736, -32'sd17885, 32'sd54736, -32'sd17885, 32'sd43936,       // 900 Hz
        32'sd60863, -32'sd78002, 32'sd60863, -32'sd78002, 32'sd56191,       // 560 Hz
        32'sd64143, -32'sd125228, 32'sd64143, -32'sd125228, 32'sd62751,     // 140 Hz
        32'sd64337, -32'sd126416, 32'sd64337, -32'sd126416, 32'sd63137,     // 120 Hz
        32'sd64531, -32'sd127490, 32'sd64531, -32'sd127490, 32'sd63527,     // 100 Hz
        32'sd432909, -32'sd432167, 32'sd0, -32'sd65536, 32'sd0,             // pos integrator
        32'sd61913, -32'sd100404, 32'sd61913, -32'sd100404, 32'sd58289      // pos 400 Hz
    };

    function automatic logic signed [COEF_W-1:0] grlc_coef(input logic [STAGE_W-1:0] s,
                                                           input logic [TAP_W-1:0]   k);
        return COEF_TABLE[int'(s) * TAPS + int'(k)];
    endfunction

    // ==========================================================
    // state machines
    typedef enum logic [2:0] {
        ACQ_IDLE, ACQ_HOLD, ACQ_START, ACQ_BUSY, ACQ_CONV, ACQ_LATCH
    } grlc_acq_type;

    typedef enum logic [1:0] {
        CMP_IDLE, CMP_MAC, CMP_ROUND, CMP_OUT
    } grlc_cmp_type;

endpackage

// ### grlc_fifo.sv
// sample fifo between converter acquisition and the filter engine
`timescale 1ns/100ps
module grlc_fifo #(
    parameter int WIDTH = grlc_pkg::WORD_W,
    parameter int DEPTH = grlc_pkg::FIFO_DEPTH
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    import grlc_pkg::*;

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wr;
        logic [AW:0]                 rd;
    } grlc_fifo_state_type;

    grlc_fifo_state_type s_reg;
    grlc_fifo_state_type s_next;
    logic                full;
    logic                empty;

    // ==========================================================
    // pointers carry a wrap bit so full and empty stay distinct
    assign full      = (s_reg.wr[AW] != s_reg.rd[AW]) && (s_reg.wr[AW-1:0] == s_reg.rd[AW-1:0]);
    assign empty     = (s_reg.wr == s_reg.rd);
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = s_reg.mem[s_reg.rd[AW-1:0]];

    always_comb begin
        s_next = s_reg;
        if (in_valid && !full) begin
            s_next.mem[s_reg.wr[AW-1:0]] = in_data;
            s_next.wr = s_reg.wr + 1'b1;
        end
        if (out_ready && !empty) begin
            s_next.rd = s_reg.rd + 1'b1;
        end
        if (flush) begin
            s_next.wr = '0;
            s_next.rd = '0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule // grlc_fifo

// ### grlc_compensator.sv
// gyro rate loop compensator: sample timing, converter sequencing and filter cascade
//
// Summary of operation
// R1: one sample pass every 4020 Hz tick
// R2: rate path: 1st, 2nd order, six notches
// R3: rate first-order stage, gain 0.1244
// R4: rate second-order stage, gain 754.7101
// R5: 1800 Hz notch coefficients
// R6: 900 Hz notch coefficients
// R7: 560 Hz notch coefficients
// R8: 140 Hz notch coefficients
// R9: 120 Hz notch coefficients
// R10: 100 Hz notch coefficients
// R11: position integrating first-order compensator
// R12: position 400 Hz notch coefficients
// R13: tick locked to 30 Hz tracker frames
// R14: ordered hold, select, start, latch strobes
// R15: host may interrupt or halt anytime
// R16: each tick starts conversion and pass if acquisition is idle and not halted
// R17: overflow check before output register
// R18: converter data twelve bits wide
// R19: cascade order first, second, notches descending
// R20: fixed-point coefficients, wide accumulate, round
`timescale 1ns/100ps
module grlc_compensator #(
    parameter int TICK_CYCLES = grlc_pkg::TICK_CYCLES
) (
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    input  wire logic                       frame_sync,
    input  wire logic                       host_halt,
    input  wire logic                       host_intr,
    input  wire logic                       adc_busy,
    input  wire logic [grlc_pkg::ADC_W-1:0] adc_data,
    output logic                            sample_hold,
    output logic [grlc_pkg::CH_W-1:0]       mux_sel,
    output logic                            adc_start,
    output logic                            in_latch,
    output logic                            dac_load,
    output logic [grlc_pkg::DAC_W-1:0]      dac_rate,
    output logic [grlc_pkg::DAC_W-1:0]      dac_pos,
    output logic                            overflow,
    output logic                            halted,
    output logic                            frame_locked
);
    import grlc_pkg::*;

    typedef struct packed {
        logic [1:0]                          sync_busy;
        logic [1:0]                          sync_frame;
        logic [1:0]                          sync_halt;
        logic [1:0]                          sync_intr;
        logic [1:0][ADC_W-1:0]               sync_data;
        logic                                frame_prev;
        logic                                intr_prev;
        logic [TICK_W-1:0]                   tick_cnt;
        logic [FRAME_W-1:0]                  frame_ticks;
        logic                                frame_locked;
        grlc_acq_type                        acq;
        logic [TIME_W-1:0]                   acq_cnt;
        logic [CH_W-1:0]                     acq_ch;
        logic                                sample_hold;
        logic [CH_W-1:0]                     mux_sel;
        logic                                adc_start;
        logic                                in_latch;
        grlc_cmp_type                        cmp;
        logic [CH_W-1:0]                     cmp_ch;
        logic [STAGE_W-1:0]                  stage;
        logic [TAP_W-1:0]                    tap;
        logic [SAMPLE_W-1:0]                 x;
        logic [ACC_W-1:0]                    acc;
        logic [NUM_STAGES-1:0][SAMPLE_W-1:0] hx1;
        logic [NUM_STAGES-1:0][SAMPLE_W-1:0] hx2;
        logic [NUM_STAGES-1:0][SAMPLE_W-1:0] hy1;
        logic [NUM_STAGES-1:0][SAMPLE_W-1:0] hy2;
        logic [DAC_W-1:0]                    dac_rate;
        logic [DAC_W-1:0]                    dac_pos;
        logic                                dac_load;
        logic                                overflow;
        logic                                halted;
    } grlc_state_type;

    grlc_state_type     s_reg;
    grlc_state_type     s_next;
    logic               fifo_in_valid;
    logic               fifo_in_ready;
    logic               fifo_out_valid;
    logic               fifo_out_ready;
    logic [WORD_W-1:0]  fifo_out_data;
    logic               fifo_flush;

    // ==========================================================
    // arithmetic helpers
    // round the accumulator back to sample width and saturate
    function automatic logic [SAMPLE_W-1:0] round_sat(input logic [ACC_W-1:0] a);
        logic signed [ACC_W-1:0] r;
        r = ($signed(a) + $signed(ROUND_HALF)) >>> COEF_FRAC; // R20
        if (r[ACC_W-1:SAMPLE_W-1] == {(ACC_W - SAMPLE_W + 1){r[ACC_W-1]}}) begin
            return r[SAMPLE_W-1:0];
        end
        return {r[ACC_W-1], {(SAMPLE_W - 1){~r[ACC_W-1]}}};
    endfunction

    // flag and clip a sample that does not fit the converter word
    function automatic logic [DAC_W:0] out_sat(input logic [SAMPLE_W-1:0] v);
        if (v[SAMPLE_W-1:DAC_W-1] == {(SAMPLE_W - DAC_W + 1){v[SAMPLE_W-1]}}) begin
            return {1'b0, v[DAC_W-1:0]};
        end
        return {1'b1, v[SAMPLE_W-1], {(DAC_W - 1){~v[SAMPLE_W-1]}}}; // R17
    endfunction

    // ==========================================================
    // next state
    always_comb begin
        logic                    frame_edge;
        logic                    intr_edge;
        logic                    halt;
        logic                    tick;
        logic                    hold_tick;
        logic signed [ACC_W-1:0] cx;
        logic signed [ACC_W-1:0] ox;
        logic signed [ACC_W-1:0] prod;
        logic [SAMPLE_W-1:0]     operand;
        logic [SAMPLE_W-1:0]     y;
        logic [DAC_W:0]          clip;

        s_next     = s_reg;
        frame_edge = s_reg.sync_frame[1] & ~s_reg.frame_prev;
        intr_edge  = s_reg.sync_intr[1] & ~s_reg.intr_prev;
        halt       = s_reg.sync_halt[1];
        operand    = s_reg.x;
        y          = '0;
        clip       = '0;
        tick       = 1'b0;
        hold_tick  = 1'b0;
        cx         = '0;
        ox         = '0;
        prod       = '0;

        // pins pass two flip-flops before use
        s_next.sync_busy  = {s_reg.sync_busy[0], adc_busy};
        s_next.sync_frame = {s_reg.sync_frame[0], frame_sync};
        s_next.sync_halt  = {s_reg.sync_halt[0], host_halt};
        s_next.sync_intr  = {s_reg.sync_intr[0], host_intr};
        s_next.sync_data  = {s_reg.sync_data[0], adc_data}; // R18
        s_next.frame_prev = s_reg.sync_frame[1];
        s_next.intr_prev  = s_reg.sync_intr[1];
        s_next.halted     = halt; // R15
        s_next.in_latch   = 1'b0;
        s_next.dac_load   = 1'b0;

        // sample tick, realigned by every tracker frame
        hold_tick = s_reg.frame_locked &&
                    (s_reg.frame_ticks >= FRAME_W'(TICKS_PER_FRAME - 1)); // R13
        tick = frame_edge ||
               (!hold_tick && (s_reg.tick_cnt >= TICK_W'(TICK_CYCLES - 1))); // R1
        if (tick) begin
            s_next.tick_cnt = '0;
        end else if (s_reg.tick_cnt < TICK_W'(TICK_CYCLES - 1)) begin
            s_next.tick_cnt = s_reg.tick_cnt + 1'b1;
        end
        if (frame_edge) begin
            s_next.frame_ticks  = '0;
            s_next.frame_locked = (s_reg.frame_ticks >= FRAME_W'(TICKS_PER_FRAME - 1)) &&
                                  (s_reg.frame_ticks <= FRAME_W'(TICKS_PER_FRAME)); // R13
        end else if (tick && (s_reg.frame_ticks != '1)) begin
            s_next.frame_ticks = s_reg.frame_ticks + 1'b1;
        end

        // ==========================================================
        // converter sequencing: hold, select, start, wait, latch
        fifo_in_valid = (s_reg.acq == ACQ_LATCH);
        case (s_reg.acq)
            ACQ_IDLE: begin
                if (tick && !halt) begin // R16
                    s_next.sample_hold = 1'b1; // R14
                    s_next.acq_ch      = CH_RATE;
                    s_next.mux_sel     = CH_RATE;
                    s_next.acq_cnt     = '0;
                    s_next.acq         = ACQ_HOLD;
                end
            end
            ACQ_HOLD: begin
                s_next.acq_cnt = s_reg.acq_cnt + 1'b1;
                if (s_reg.acq_cnt == TIME_W'(SH_CYCLES - 1)) begin
                    s_next.adc_start = 1'b1; // R14
                    s_next.acq_cnt   = '0;
                    s_next.acq       = ACQ_START;
                end
            end
            ACQ_START: begin
                s_next.acq_cnt = s_reg.acq_cnt + 1'b1;
                if (s_reg.acq_cnt == TIME_W'(START_CYCLES - 1)) begin
                    s_next.adc_start = 1'b0;
                    s_next.acq       = ACQ_BUSY;
                end
            end
            ACQ_BUSY: begin
                if (s_reg.sync_busy[1]) begin
                    s_next.acq = ACQ_CONV;
                end
            end
            ACQ_CONV: begin
                if (!s_reg.sync_busy[1]) begin
                    s_next.acq = ACQ_LATCH;
                end
            end
            ACQ_LATCH: begin
                if (fifo_in_ready) begin
                    s_next.in_latch = 1'b1; // R14
                    if (s_reg.acq_ch == CH_POS) begin
                        s_next.sample_hold = 1'b0;
                        s_next.acq         = ACQ_IDLE;
                    end else begin
                        s_next.acq_ch    = CH_POS;
                        s_next.mux_sel   = CH_POS;
                        s_next.adc_start = 1'b1;
                        s_next.acq_cnt   = '0;
                        s_next.acq       = ACQ_START;
                    end
                end
            end
            default: begin
                s_next.acq = ACQ_IDLE;
            end
        endcase

        // ==========================================================
        // filter engine: one multiply-accumulate per cycle, five taps a stage
        case (s_reg.tap)
            3'h1: operand = s_reg.hx1[s_reg.stage];
            3'h2: operand = s_reg.hx2[s_reg.stage];
            3'h3: operand = s_reg.hy1[s_reg.stage];
            3'h4: operand = s_reg.hy2[s_reg.stage];
            default: operand = s_reg.x;
        endcase
        cx   = ACC_W'(grlc_coef(s_reg.stage, s_reg.tap)); // R3 R4 R5 R6 R7 R8 R9 R10 R11 R12
        ox   = ACC_W'($signed(operand));
        prod = cx * ox; // R20

        fifo_out_ready = (s_reg.cmp == CMP_IDLE) && !halt; // R15
        case (s_reg.cmp)
            CMP_IDLE: begin
                if (fifo_out_valid && !halt) begin
                    s_next.cmp_ch = fifo_out_data[WORD_W-1:ADC_W];
                    s_next.x      = {{(SAMPLE_W - ADC_W){fifo_out_data[ADC_W-1]}},
                                     fifo_out_data[ADC_W-1:0]};
                    s_next.stage  = (fifo_out_data[WORD_W-1:ADC_W] == CH_POS) ?
                                    POS_FIRST : RATE_FIRST; // R2
                    s_next.tap    = '0;
                    s_next.acc    = '0;
                    s_next.cmp    = CMP_MAC;
                end
            end
            CMP_MAC: begin
                if (s_reg.tap < TAP_W'(FIRST_A_TAP)) begin
                    s_next.acc = ACC_W'($signed(s_reg.acc) + prod);
                end else begin
                    s_next.acc = ACC_W'($signed(s_reg.acc) - prod);
                end
                s_next.tap = s_reg.tap + 1'b1;
                if (s_reg.tap == TAP_W'(TAPS - 1)) begin
                    s_next.cmp = CMP_ROUND;
                end
            end
            CMP_ROUND: begin
                y = round_sat(s_reg.acc); // R20
                s_next.hx2[s_reg.stage] = s_reg.hx1[s_reg.stage];
                s_next.hx1[s_reg.stage] = s_reg.x;
                s_next.hy2[s_reg.stage] = s_reg.hy1[s_reg.stage];
                s_next.hy1[s_reg.stage] = y;
                s_next.x   = y; // R19
                s_next.tap = '0;
                s_next.acc = '0;
                if ((s_reg.stage == RATE_LAST) || (s_reg.stage == POS_LAST)) begin
                    s_next.cmp = CMP_OUT;
                end else begin
                    s_next.stage = s_reg.stage + 1'b1; // R19
                    s_next.cmp   = CMP_MAC;
                end
            end
            CMP_OUT: begin
                clip = out_sat(s_reg.x); // R17
                if (s_reg.cmp_ch == CH_POS) begin
                    s_next.dac_pos  = clip[DAC_W-1:0];
                    s_next.overflow = s_reg.overflow | clip[DAC_W];
                    s_next.dac_load = 1'b1;
                end else begin
                    s_next.dac_rate = clip[DAC_W-1:0];
                    s_next.overflow = clip[DAC_W];
                end
                s_next.cmp = CMP_IDLE;
            end
            default: begin
                s_next.cmp = CMP_IDLE;
            end
        endcase

        // host interrupt abandons the pass and clears filter history
        fifo_flush = intr_edge;
        if (intr_edge) begin // R15
            s_next.acq         = ACQ_IDLE;
            s_next.sample_hold = 1'b0;
            s_next.adc_start   = 1'b0;
            s_next.in_latch    = 1'b0;
            s_next.cmp         = CMP_IDLE;
            s_next.dac_load    = 1'b0;
            s_next.hx1         = '0;
            s_next.hx2         = '0;
            s_next.hy1         = '0;
            s_next.hy2         = '0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // sample buffer
    grlc_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .flush     (fifo_flush),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({s_reg.acq_ch, s_reg.sync_data[1]}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    assign sample_hold  = s_reg.sample_hold;
    assign mux_sel      = s_reg.mux_sel;
    assign adc_start    = s_reg.adc_start;
    assign in_latch     = s_reg.in_latch;
    assign dac_load     = s_reg.dac_load;
    assign dac_rate     = s_reg.dac_rate;
    assign dac_pos      = s_reg.dac_pos;
    assign overflow     = s_reg.overflow;
    assign halted       = s_reg.halted;
    assign frame_locked = s_reg.frame_locked;

endmodule // grlc_compensator

// ### grlc_conv_model.sv
// behavioural converter with channel select input for the compensator
`timescale 1ns/100ps
module grlc_conv_model (
    input  wire logic        core_clk,
    input  wire logic        adc_start,
    input  wire logic [0:0]  mux_sel,
    input  wire logic [7:0]  conv_len,
    input  wire logic [11:0] rate_val,
    input  wire logic [11:0] pos_val,
    output logic             adc_busy,
    output logic [11:0]      adc_data
);
    logic [0:0] ch;
    initial begin
        adc_busy = 1'b0;
        adc_data = 12'h5a5;
        forever begin
            @(posedge adc_start);
            ch = mux_sel;
            repeat (2) @(posedge core_clk);
            #2 adc_busy = 1'b1;
            adc_data = ~adc_data; // word is invalid while converting
            repeat (conv_len) @(posedge core_clk);
            #2 adc_data = ch ? pos_val : rate_val;
            adc_busy = 1'b0;
        end
    end
endmodule // grlc_conv_model

// ### grlc_props.sv
// port assertions for the compensator
`timescale 1ns/100ps
module grlc_props (
    input wire logic                       core_clk,
    input wire logic                       rst,
    input wire logic                       sample_hold,
    input wire logic [grlc_pkg::CH_W-1:0]  mux_sel,
    input wire logic                       adc_start,
    input wire logic                       in_latch,
    input wire logic                       dac_load,
    input wire logic [grlc_pkg::DAC_W-1:0] dac_pos,
    input wire logic                       halted
);
    import grlc_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_start_in_hold: assert property ($rose(adc_start) |-> sample_hold)
        else $error("start outside hold");
    a_start_width: assert property ($rose(adc_start) |-> adc_start [*4] ##1 !adc_start)
        else $error("start pulse width wrong");
    a_hold_settle: assert property ($rose(sample_hold) |-> ##[39:41] $rose(adc_start))
        else $error("start not after settle time");
    a_hold_rate_first: assert property ($rose(sample_hold) |-> mux_sel == CH_RATE)
        else $error("pass does not begin on rate channel");
    a_load_pulse: assert property (dac_load |=> !dac_load)
        else $error("load longer than one cycle");
    a_pos_steady: assert property (!dac_load |-> $stable(dac_pos))
        else $error("position output changed without load");
    a_halt_blocks: assert property (halted [*3] |-> !$rose(sample_hold))
        else $error("pass started while halted");
    a_latch_in_hold: assert property (in_latch |-> $past(sample_hold))
        else $error("latch outside acquisition");
endmodule // grlc_props
bind grlc_compensator grlc_props props_u (.core_clk, .rst, .sample_hold, .mux_sel,
    .adc_start, .in_latch, .dac_load, .dac_pos, .halted);

// ### tb_grlc_compensator.sv
// self-checking bench for the gyro rate loop compensator
`timescale 1ns/100ps
module tb_grlc_compensator;
    import grlc_pkg::*;
    localparam int TK = 400;
    logic core_clk = 0, rst = 1, frame_sync = 0, host_halt = 0, host_intr = 0;
    logic adc_busy, sample_hold, adc_start, in_latch, dac_load, overflow, halted, frame_locked;
    logic [11:0] adc_data, dac_rate, dac_pos, rate_val = 0, pos_val = 0;
    logic [7:0] conv_len = 3;
    logic [0:0] mux_sel;
    int miscompares = 0, checked = 0, cyc = 0;
    grlc_compensator #(.TICK_CYCLES(TK)) dut_u (.core_clk, .rst, .frame_sync, .host_halt,
        .host_intr, .adc_busy, .adc_data, .sample_hold, .mux_sel, .adc_start, .in_latch,
        .dac_load, .dac_rate, .dac_pos, .overflow, .halted, .frame_locked);
    grlc_conv_model conv_u (.core_clk, .adc_start, .mux_sel, .conv_len, .rate_val,
        .pos_val, .adc_busy, .adc_data);
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 80000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (miscompares == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [11:0] e, input logic [11:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // zero-history cascade: each stage reduces to its leading tap, rounded and saturated
    function automatic logic [11:0] model(input int x, input int f, input int l, output logic ov);
        longint y;
        y = x;
        for (int s = f; s <= l; s++) begin
            y = (y * COEF_TABLE[s*TAPS] + 32768) >>> 16;
            if (y > 8388607) y = 8388607;
            if (y < -8388608) y = -8388608;
        end
        ov = (y > 2047) || (y < -2048);
        if (y > 2047) y = 2047;
        if (y < -2048) y = -2048;
        return y[11:0];
    endfunction
    task automatic wait_load();
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            #2 n++;
        end while (dac_load !== 1'b1 && n < 3*TK);
        if (n == 3*TK) cmp("dac_load", 12'h1, 12'h0);
    endtask
    task automatic t_pass(input int rv, input int pv, input logic [7:0] cl);
        logic ovr, ovp;
        logic [11:0] er, ep;
        wait_load();
        rate_val = rv[11:0];
        pos_val = pv[11:0];
        conv_len = cl;
        host_intr = 1; // history cleared so the pass starts from zero state
        repeat (4) @(posedge core_clk);
        #2 host_intr = 0;
        er = model(rv, 0, 7, ovr);
        ep = model(pv, 8, 9, ovp);
        wait_load();
        cmp("dac_rate", er, dac_rate);
        cmp("dac_pos", ep, dac_pos);
        cmp("overflow", {11'h0, ovr | ovp}, {11'h0, overflow});
    endtask
    task automatic t_halt();
        int r;
        logic p;
        r = 0;
        wait_load();
        host_halt = 1;
        repeat (2*TK) begin
            p = sample_hold;
            @(posedge core_clk);
            #2 if (sample_hold && !p) r++;
        end
        cmp("halted", 12'h1, {11'h0, halted});
        cmp("starts while halted", 12'h0, r[11:0]);
        host_halt = 0;
    endtask
    task automatic t_frame();
        int n;
        for (int f = 0; f < 2; f++) begin
            n = 0;
            repeat (f ? 134 : 1) wait_load(); // second frame after 133 natural ticks
            repeat (20) @(posedge core_clk);
            #2 frame_sync = 1;
            while (sample_hold !== 1'b1 && n < 20) begin
                @(posedge core_clk);
                #2 n++;
            end
            cmp("frame to hold", 12'h1, {11'h0, n inside {[3:6]}});
            cmp("frame_locked", f[11:0], {11'h0, frame_locked});
            frame_sync = 0;
        end
    endtask
    task automatic t_period();
        int n;
        int m;
        logic p;
        n = 0;
        m = 0;
        while (m < 2) begin
            p = sample_hold;
            @(posedge core_clk);
            #2 if (m > 0) n++;
            if (sample_hold && !p) m++;
        end
        cmp("tick period", TK, n[11:0]);
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        #2 rst = 0;
        cmp("dac_rate reset", 12'h0, dac_rate);
        cmp("dac_pos reset", 12'h0, dac_pos);
        t_pass(10, 100, 3);
        t_pass(-2000, 2047, 30);
        t_halt();
        t_frame();
        t_period();
        stop_test();
    end
endmodule // tb_grlc_compensator
